// File: icm_pkg.sv
// Purpose: Shared constants for the initial channel mask register pair
// Assumes: Avalon-MM byte addressing, one aligned 32-bit word per register
// Notes: Trigger indexes select bits of the synchronised reset-event vector
package icm_pkg;
  localparam int ICM_ADDR_W = 8;
  localparam int ICM_DATA_W = 32;
  localparam int ICM_BE_W = ICM_DATA_W / 8;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_UPPER = 8'hb4;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_LOWER = 8'hb8;
  localparam logic [ICM_DATA_W-1:0] ICM_MASK_RESET = 32'hffffffff;
  localparam logic [ICM_DATA_W-1:0] ICM_READ_ZERO = 32'h00000000;
  localparam int ICM_NUM_TRIG = 3;
  localparam int ICM_TRIG_GLOBAL = 0;
  localparam int ICM_TRIG_HOST = 1;
  localparam int ICM_TRIG_SERIAL = 2;
endpackage

// File: icm_top.sv
// Purpose: Initial isochronous channel mask pair with CSR image load logic
// Assumes: soft_reset comes from logic on core_clk; bus-reset events are pins
// Notes: Each Avalon access is answered one cycle after it is presented
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module icm_top
  import icm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic global_hardware_reset,
  input wire logic host_bus_reset,
  input wire logic serial_bus_reset,
  input wire logic [ICM_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ICM_DATA_W-1:0] avs_writedata,
  input wire logic [ICM_BE_W-1:0] avs_byteenable,
  output logic [ICM_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [ICM_DATA_W-1:0] csr_channels_hi,
  output logic [ICM_DATA_W-1:0] csr_channels_lo,
  output logic csr_load_done
);
  // ---------------------------------------------------------------
  // Reset-event synchronisers
  // ---------------------------------------------------------------
  logic [ICM_NUM_TRIG-1:0] trig_raw;
  logic [ICM_NUM_TRIG-1:0] trig_rise;
  logic load_event;

  assign trig_raw[ICM_TRIG_GLOBAL] = global_hardware_reset;
  assign trig_raw[ICM_TRIG_HOST] = host_bus_reset;
  assign trig_raw[ICM_TRIG_SERIAL] = serial_bus_reset;

  icm_trig_sync #(
    .WIDTH(ICM_NUM_TRIG)
  ) u_trig_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(trig_raw),
    .level_out(),
    .rise_pulse(trig_rise)
  );

  assign load_event = |trig_rise;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  function automatic logic [ICM_DATA_W-1:0] merge_bytes(
    input logic [ICM_DATA_W-1:0] old_val,
    input logic [ICM_DATA_W-1:0] new_val,
    input logic [ICM_BE_W-1:0] be
  );
    logic [ICM_DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < ICM_BE_W; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [ICM_DATA_W-1:0] init_upper;
  logic [ICM_DATA_W-1:0] init_lower;
  logic [ICM_DATA_W-1:0] next_init_upper;
  logic [ICM_DATA_W-1:0] next_init_lower;
  logic [ICM_DATA_W-1:0] next_avs_readdata;
  logic next_avs_waitrequest;
  logic write_take;
  logic sel_upper;
  logic sel_lower;

  assign sel_upper = (avs_address == ICM_OFS_UPPER);
  assign sel_lower = (avs_address == ICM_OFS_LOWER);
  // Access completes at the edge where waitrequest is seen low
  assign write_take = avs_write && !avs_waitrequest;

  always_comb
  begin
    next_avs_waitrequest = 1'b1;
    next_avs_readdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest)
    begin
      next_avs_waitrequest = 1'b0;
      if (sel_upper)
      begin
        next_avs_readdata = init_upper;
      end
      else if (sel_lower)
      begin
        next_avs_readdata = init_lower;
      end
      else
      begin
        next_avs_readdata = ICM_READ_ZERO;
      end
    end
  end

  always_comb
  begin
    next_init_upper = init_upper;
    next_init_lower = init_lower;
    if (soft_reset)
    begin
      next_init_upper = ICM_MASK_RESET;
      next_init_lower = ICM_MASK_RESET;
    end
    else if (write_take)
    begin
      if (sel_upper)
      begin
        next_init_upper = merge_bytes(init_upper, avs_writedata, avs_byteenable);
      end
      if (sel_lower)
      begin
        next_init_lower = merge_bytes(init_lower, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      init_upper <= ICM_MASK_RESET;
      init_lower <= ICM_MASK_RESET;
      avs_readdata <= ICM_READ_ZERO;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      init_upper <= next_init_upper;
      init_lower <= next_init_lower;
      avs_readdata <= next_avs_readdata;
      avs_waitrequest <= next_avs_waitrequest;
    end
  end

  // ---------------------------------------------------------------
  // CSR image load
  // ---------------------------------------------------------------
  logic [ICM_DATA_W-1:0] next_csr_hi;
  logic [ICM_DATA_W-1:0] next_csr_lo;
  logic next_csr_load_done;

  always_comb
  begin
    next_csr_hi = csr_channels_hi;
    next_csr_lo = csr_channels_lo;
    next_csr_load_done = 1'b0;
    if (soft_reset)
    begin
      next_csr_hi = ICM_MASK_RESET;
      next_csr_lo = ICM_MASK_RESET;
      next_csr_load_done = 1'b1;
    end
    // copy stored masks; writes alone never load
    else if (load_event)
    begin
      next_csr_hi = init_upper;
      next_csr_lo = init_lower;
      next_csr_load_done = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      csr_channels_hi <= ICM_MASK_RESET;
      csr_channels_lo <= ICM_MASK_RESET;
      csr_load_done <= 1'b0;
    end
    else
    begin
      csr_channels_hi <= next_csr_hi;
      csr_channels_lo <= next_csr_lo;
      csr_load_done <= next_csr_load_done;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_copy_upper;
    @(posedge core_clk) disable iff (rst)
    (load_event && !soft_reset) |=> (csr_channels_hi == $past(init_upper)) && csr_load_done;
  endproperty
  a_copy_upper: assert property (p_copy_upper) else $error("upper CSR copy wrong");

  property p_copy_lower;
    @(posedge core_clk) disable iff (rst)
    (load_event && !soft_reset) |=> (csr_channels_lo == $past(init_lower));
  endproperty
  a_copy_lower: assert property (p_copy_lower) else $error("lower CSR copy wrong");

  property p_soft_ones;
    @(posedge core_clk) disable iff (rst)
    soft_reset |=> (init_upper == ICM_MASK_RESET) && (init_lower == ICM_MASK_RESET);
  endproperty
  a_soft_ones: assert property (p_soft_ones) else $error("mask not all ones");

  property p_serial_keeps;
    @(posedge core_clk) disable iff (rst)
    (trig_rise[ICM_TRIG_SERIAL] && !soft_reset && !write_take)
      |=> $stable(init_upper) && $stable(init_lower);
  endproperty
  a_serial_keeps: assert property (p_serial_keeps) else $error("bus reset changed mask");

  property p_soft_csr_hi;
    @(posedge core_clk) disable iff (rst)
    soft_reset |=> (csr_channels_hi == init_upper) && (csr_channels_hi == ICM_MASK_RESET);
  endproperty
  a_soft_csr_hi: assert property (p_soft_csr_hi) else $error("upper CSR not loaded");

  property p_soft_csr_lo;
    @(posedge core_clk) disable iff (rst)
    soft_reset |=> (csr_channels_lo == init_lower) && (csr_channels_lo == ICM_MASK_RESET);
  endproperty
  a_soft_csr_lo: assert property (p_soft_csr_lo) else $error("lower CSR not loaded");

  property p_write_no_load;
    @(posedge core_clk) disable iff (rst)
    (write_take && !load_event && !soft_reset)
      |=> $stable(csr_channels_hi) && $stable(csr_channels_lo) && !csr_load_done;
  endproperty
  a_write_no_load: assert property (p_write_no_load) else $error("write touched CSR");

  property p_wait_one;
    @(posedge core_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");
endmodule
`default_nettype wire

// File: icm_trig_sync.sv
// Purpose: Two-flop synchroniser with rising-edge pulse for reset events
// Assumes: Inputs are asynchronous levels from pins
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module icm_trig_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // An event held through rst still yields one pulse after release
  assign rise_pulse = stage2 & ~stage3;
  assign level_out = stage2;
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the initial channel mask register pair
// Assumes: One access answered per waitrequest low; pins pulse one copy each
// Notes: Bus tasks add an idle edge so no strobe is driven twice in one step
`timescale 1ns/10ps
`default_nettype none
module tb;
  import icm_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic soft_reset = 0;
  logic [ICM_NUM_TRIG-1:0] trig = '0;
  logic [ICM_ADDR_W-1:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [ICM_DATA_W-1:0] avs_writedata = 0;
  logic [ICM_BE_W-1:0] avs_byteenable = 0;
  logic [ICM_DATA_W-1:0] avs_readdata, csr_channels_hi, csr_channels_lo;
  logic [ICM_DATA_W-1:0] rd, exp_hi, exp_lo, wv_hi, wv_lo;
  logic avs_waitrequest, csr_load_done;
  int bad_count = 0;
  int n_tests = 0;

  icm_top icm_top_i (
    .core_clk(core_clk),
    .rst(rst),
    .soft_reset(soft_reset),
    .global_hardware_reset(trig[ICM_TRIG_GLOBAL]),
    .host_bus_reset(trig[ICM_TRIG_HOST]),
    .serial_bus_reset(trig[ICM_TRIG_SERIAL]),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .csr_channels_hi(csr_channels_hi),
    .csr_channels_lo(csr_channels_lo),
    .csr_load_done(csr_load_done)
  );

  always #4 core_clk = ~core_clk;

  // ---------------------------------------
  // Shared tasks
  // ---------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      chk("waitrequest", 32'h00000000, 32'h00000001);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  // Bounded wait of up to 20 edges for the copy pulse, then a check that it came
  task automatic wait_load();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (csr_load_done !== 1'b1 && n < 20);
    chk("csr_load_done", 32'h00000001, {31'h0, csr_load_done});
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ---------------------------------------
  // Test sequence
  // ---------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, ICM_OFS_UPPER, 0, 4'hf, rd);
    chk("upper_reset", ICM_MASK_RESET, rd);
    bus(1'b0, ICM_OFS_LOWER, 0, 4'hf, rd);
    chk("lower_reset", ICM_MASK_RESET, rd);
    chk("csr_hi_reset", ICM_MASK_RESET, csr_channels_hi);
    chk("csr_lo_reset", ICM_MASK_RESET, csr_channels_lo);
    bus(1'b0, 8'hb0, 0, 4'hf, rd);
    chk("unmapped_read", ICM_READ_ZERO, rd);
    exp_hi = ICM_MASK_RESET;
    exp_lo = ICM_MASK_RESET;
    // Each trigger pin in turn; none of them may touch the masks
    for (int k = 0; k < ICM_NUM_TRIG; k++)
    begin
      wv_hi = 32'h13570000 + 32'(k);
      wv_lo = 32'h2468ace0 + 32'(k);
      bus(1'b1, ICM_OFS_UPPER, wv_hi, 4'hf, rd);
      bus(1'b1, ICM_OFS_LOWER, wv_lo, 4'hf, rd);
      chk("csr_hi_held", exp_hi, csr_channels_hi);
      chk("csr_lo_held", exp_lo, csr_channels_lo);
      trig[k] <= 1'b1;
      wait_load();
      trig[k] <= 1'b0;
      exp_hi = wv_hi;
      exp_lo = wv_lo;
      chk("csr_hi_copy", exp_hi, csr_channels_hi);
      chk("csr_lo_copy", exp_lo, csr_channels_lo);
      bus(1'b0, ICM_OFS_UPPER, 0, 4'hf, rd);
      chk("upper_kept", wv_hi, rd);
      bus(1'b0, ICM_OFS_LOWER, 0, 4'hf, rd);
      chk("lower_kept", wv_lo, rd);
      repeat (4) @(posedge core_clk);
    end
    bus(1'b1, ICM_OFS_UPPER, 32'hdeadbeef, 4'b0101, rd);
    bus(1'b0, ICM_OFS_UPPER, 0, 4'hf, rd);
    chk("upper_lanes", {exp_hi[31:24], 8'had, exp_hi[15:8], 8'hef}, rd);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    wait_load();
    chk("csr_hi_soft", ICM_MASK_RESET, csr_channels_hi);
    chk("csr_lo_soft", ICM_MASK_RESET, csr_channels_lo);
    bus(1'b0, ICM_OFS_UPPER, 0, 4'hf, rd);
    chk("upper_soft", ICM_MASK_RESET, rd);
    bus(1'b0, ICM_OFS_LOWER, 0, 4'hf, rd);
    chk("lower_soft", ICM_MASK_RESET, rd);
    // Mid-run system reset must bring back ones after a non-ones copy
    bus(1'b1, ICM_OFS_LOWER, 32'h0000ffff, 4'hf, rd);
    trig[ICM_TRIG_HOST] <= 1'b1;
    wait_load();
    trig[ICM_TRIG_HOST] <= 1'b0;
    chk("csr_lo_host", 32'h0000ffff, csr_channels_lo);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("csr_lo_rst", ICM_MASK_RESET, csr_channels_lo);
    chk("load_done_rst", 32'h00000000, {31'h0, csr_load_done});
    bus(1'b0, ICM_OFS_LOWER, 0, 4'hf, rd);
    chk("lower_rst", ICM_MASK_RESET, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
